// File: hdl/sleep_wake_pin_control.sv
// Purpose: pin-level control of the retimer: sleep indicator, wake, host serial
//          enables, eeprom strobe, cable-present, clock input mode, aux outputs
// Assumes: one clock at 25 MHz; reset synchronous, active low
// Notes:   wake edge is caught by an async latch so it survives a stopped clock
//
// Behaviour
// - oscillator enable output is high during normal operation.
// - entering deep sleep drives oscillator enable output low.
// - oscillator enable stays low until host serial input transitions.
// - falling edge on host serial input during sleep raises oscillator enable.
// - level shift enable high signals host serial interface operational.
// - host serial output is high impedance while level shift enable low.
// - eeprom write strobe pulled low only while writing the eeprom.
// - cable present output goes high once operation is stable.
// - select low chooses crystal or single-ended clock input mode.
// - select high chooses differential reference clock input mode.
// - reset low returns all internal state to reset values.
// - each aux output is serial or gpio, push-pull or open drain.
// - device is i2c master driving open-drain clock near 400 kHz.
module sleep_wake_pin_control
  import pin_ctrl_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES = SETTLE_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        host_serial_in,
  input  wire logic        clock_input_select,
  input  wire logic        sleep_req,
  input  wire logic        host_if_active,
  input  wire logic        host_tx_data,
  input  wire logic        eeprom_write_active,
  input  wire logic        i2c_run,
  input  wire logic        scl_in,
  input  wire logic [1:0]  aux_serial_data,
  input  wire aux_cfg_t    aux_cfg_one,
  input  wire aux_cfg_t    aux_cfg_two,
  output logic             oscillator_enable_out,
  output logic             level_shift_enable,
  output logic             host_serial_out,
  output logic             host_serial_out_oe,
  output logic             eeprom_write_strobe,
  output logic             eeprom_write_strobe_oe,
  output logic             cable_present_out,
  output clkin_mode_t      clkin_mode,
  output logic             scl_out,
  output logic             scl_oe,
  output logic             aux_serial_out_one,
  output logic             aux_serial_out_one_oe,
  output logic             aux_serial_out_two,
  output logic             aux_serial_out_two_oe,
  output logic             sleeping
);

  pwr_state_t       state_q;
  logic [CNT_W-1:0] settle_q;
  logic             wake_latch_q;
  logic             wake_arm_q;
  logic             wake_seen;
  logic             wake_clr_q;
  logic             mode_sync;
  logic [CNT_W-1:0] div_q;
  logic             tick;
  logic [1:0]       phase_q;
  logic [1:0]       phase_nxt;

  function automatic pin_drive_t aux_drive(input aux_cfg_t cfg, input logic ser);
    logic v;
    v = cfg.gpio_sel ? cfg.gpio_val : ser;
    aux_drive.out = cfg.open_drain ? LOW : v;
    aux_drive.oe  = cfg.open_drain ? ~v : HIGH;
  endfunction

  // ==========================================================================
  // wake edge latch
  // set by the pin's falling edge itself, no clock needed; cleared only by
  // the synchronous handshake once the clock runs again
  always_ff @(negedge host_serial_in or posedge wake_clr_q) begin
    if (wake_clr_q) begin
      wake_latch_q <= LOW;
    end else begin
      wake_latch_q <= wake_arm_q;
    end
  end

  pin_sync3 #(.RST_VAL(LOW)) u_wake_sync (
    .clk     (clk),
    .rst_n   (rst_n),
    .pin     (wake_latch_q),
    .level_q (wake_seen)
  );

  pin_sync3 #(.RST_VAL(LOW)) u_mode_sync (
    .clk     (clk),
    .rst_n   (rst_n),
    .pin     (clock_input_select),
    .level_q (mode_sync)
  );

  // ==========================================================================
  // power state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q  <= PWR_SETTLE;
      settle_q <= '0;
    end else begin
      case (state_q)
        PWR_SETTLE: begin
          if (settle_q == CNT_W'(SETTLE_CYCLES - 1)) begin
            state_q <= PWR_RUN;
          end else begin
            settle_q <= settle_q + CNT_W'(1);
          end
        end
        PWR_RUN: begin
          if (sleep_req) begin
            state_q <= PWR_SLEEP;
          end
        end
        PWR_SLEEP: begin
          if (wake_seen) begin
            state_q <= PWR_WAKE;
          end
        end
        PWR_WAKE: begin
          if (!wake_seen) begin
            state_q <= PWR_RUN;
          end
        end
        default: state_q <= PWR_SETTLE;
      endcase
    end
  end

  // arm the latch only in sleep; clear it after wake is seen
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wake_arm_q <= LOW;
      wake_clr_q <= HIGH;
    end else begin
      wake_arm_q <= (state_q == PWR_SLEEP);
      wake_clr_q <= (state_q != PWR_SLEEP);
    end
  end

  // ==========================================================================
  // indicator outputs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      oscillator_enable_out <= OSC_EN_RST;
      sleeping              <= LOW;
      cable_present_out     <= LOW;
    end else begin
      oscillator_enable_out <= (state_q != PWR_SLEEP);
      sleeping              <= (state_q == PWR_SLEEP);
      cable_present_out     <= (state_q != PWR_SETTLE);
    end
  end

  // ==========================================================================
  // host serial interface
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      level_shift_enable <= LOW;
      host_serial_out    <= HIGH;
      host_serial_out_oe <= LOW;
    end else begin
      level_shift_enable <= host_if_active && (state_q == PWR_RUN);
      host_serial_out    <= host_tx_data;
      host_serial_out_oe <= host_if_active && (state_q == PWR_RUN);
    end
  end

  // ==========================================================================
  // eeprom strobe, open drain
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      eeprom_write_strobe    <= LOW;
      eeprom_write_strobe_oe <= LOW;
    end else begin
      eeprom_write_strobe    <= LOW;
      eeprom_write_strobe_oe <= eeprom_write_active;
    end
  end

  // ==========================================================================
  // clock input mode, follows the filtered select pin
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      clkin_mode <= CLKIN_XTAL_SE;
    end else begin
      clkin_mode <= mode_sync ? CLKIN_DIFF : CLKIN_XTAL_SE;
    end
  end

  // ==========================================================================
  // i2c clock: quarter-period tick, open drain with clock stretching seen
  // through scl_in; scl_in is assumed already synchronous to clk
  assign tick = (div_q == CNT_W'(I2C_QTR_CYC - 1));
  // scl is pulled low for the first two quarters of a period, released for the last two
  assign phase_nxt = phase_q + 2'h1;

  always_ff @(posedge clk) begin
    if (!rst_n || !i2c_run) begin
      div_q <= '0;
    end else if (tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + CNT_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      phase_q <= '0;
      scl_out <= LOW;
      scl_oe  <= LOW;
    end else if (!i2c_run) begin
      phase_q <= '0;
      scl_oe  <= LOW;
    end else if (tick && !(phase_q[1] && !scl_in && !scl_oe)) begin
      phase_q <= phase_nxt;
      scl_oe  <= ~phase_nxt[1];
    end
  end

  // ==========================================================================
  // aux outputs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      {aux_serial_out_one, aux_serial_out_one_oe} <= {HIGH, LOW};
      {aux_serial_out_two, aux_serial_out_two_oe} <= {HIGH, LOW};
    end else begin
      {aux_serial_out_one, aux_serial_out_one_oe} <= aux_drive(aux_cfg_one, aux_serial_data[0]);
      {aux_serial_out_two, aux_serial_out_two_oe} <= aux_drive(aux_cfg_two, aux_serial_data[1]);
    end
  end

  // ==========================================================================
  // checks
  property p_osc_low_in_sleep;
    @(posedge clk) disable iff (!rst_n)
    (state_q == PWR_SLEEP) |=> !oscillator_enable_out;
  endproperty
  a_osc_low_in_sleep: assert property (p_osc_low_in_sleep)
    else $error("oscillator enable high in sleep");

  property p_sleep_flag;
    @(posedge clk) disable iff (!rst_n)
    $rose(sleeping) |-> !oscillator_enable_out;
  endproperty
  a_sleep_flag: assert property (p_sleep_flag)
    else $error("sleep flag and oscillator enable disagree");

  property p_stay_low;
    @(posedge clk) disable iff (!rst_n)
    (state_q == PWR_SLEEP) && !wake_seen |=> !oscillator_enable_out;
  endproperty
  a_stay_low: assert property (p_stay_low)
    else $error("oscillator enable rose without wake");

  sequence s_wake;
    (state_q == PWR_SLEEP) ##0 wake_seen;
  endsequence
  property p_wake;
    @(posedge clk) disable iff (!rst_n)
    s_wake |-> ##2 oscillator_enable_out;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake edge did not raise oscillator enable");

  property p_run_high;
    @(posedge clk) disable iff (!rst_n)
    (state_q == PWR_RUN) |=> oscillator_enable_out;
  endproperty
  a_run_high: assert property (p_run_high)
    else $error("oscillator enable low in run");

  property p_tristate;
    @(posedge clk) disable iff (!rst_n)
    !level_shift_enable |-> !host_serial_out_oe;
  endproperty
  a_tristate: assert property (p_tristate)
    else $error("host serial out driven while level shift off");

  property p_eeprom;
    @(posedge clk) disable iff (!rst_n)
    eeprom_write_active |=> eeprom_write_strobe_oe && !eeprom_write_strobe;
  endproperty
  a_eeprom: assert property (p_eeprom)
    else $error("eeprom strobe not low during write");

  property p_cable;
    @(posedge clk) disable iff (!rst_n)
    (state_q == PWR_RUN) |=> cable_present_out;
  endproperty
  a_cable: assert property (p_cable)
    else $error("cable present low after settle");

  property p_mode;
    @(posedge clk) disable iff (!rst_n)
    mode_sync |=> (clkin_mode == CLKIN_DIFF);
  endproperty
  a_mode: assert property (p_mode)
    else $error("clock input mode wrong");

  property p_scl_od;
    @(posedge clk) disable iff (!rst_n)
    scl_oe |-> !scl_out;
  endproperty
  a_scl_od: assert property (p_scl_od)
    else $error("scl driven high");

endmodule

// File: include/pin_ctrl_pkg.sv
// Purpose: shared constants and carrier types for the sleep/wake pin control block
// Assumes: one 25 MHz clock, synchronous active-low reset
// Notes:   clock figures are kept in their own units, the i2c cycle counts derive from them
package pin_ctrl_pkg;

  // ==========================================================================
  // timing
  localparam int unsigned CLK_HZ        = 25_000_000;
  localparam int unsigned I2C_SCL_HZ    = 400_000;
  // quarter of an scl period, rounded down so the bus never runs slower than asked
  localparam int unsigned I2C_QTR_CYC_R = CLK_HZ / (4 * I2C_SCL_HZ);
  localparam int unsigned I2C_QTR_CYC   = (I2C_QTR_CYC_R < 1) ? 1 : I2C_QTR_CYC_R;
  localparam int unsigned SETTLE_CYC    = 16;
  localparam int unsigned CNT_W         = 16;

  // ==========================================================================
  // reset values
  localparam logic        OSC_EN_RST    = 1'h1;
  localparam logic        HIGH          = 1'h1;
  localparam logic        LOW           = 1'h0;

  // ==========================================================================
  // modes
  typedef enum logic [1:0] {
    PWR_SETTLE = 2'h0,
    PWR_RUN    = 2'h1,
    PWR_SLEEP  = 2'h2,
    PWR_WAKE   = 2'h3
  } pwr_state_t;

  typedef enum logic {
    CLKIN_XTAL_SE = 1'h0,
    CLKIN_DIFF    = 1'h1
  } clkin_mode_t;

  // aux output configuration, set by the on-chip microcontroller
  typedef struct packed {
    logic gpio_sel;    // 1: pin shows gpio_val, 0: pin shows serial data
    logic open_drain;  // 1: only drive low
    logic gpio_val;
  } aux_cfg_t;

  // one pin driven by the block
  typedef struct packed {
    logic out;
    logic oe;
  } pin_drive_t;

endpackage

// File: hdl/pin_sync3.sv
// Purpose: three-flop synchroniser with agreement filter for one pin
// Assumes: input comes from outside the clock domain
// Notes:   stage one is read only by stage two
module pin_sync3
  import pin_ctrl_pkg::*;
#(
  parameter logic RST_VAL = 1'h1
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic pin,
  output logic      level_q
);

  logic s1_q;
  logic s2_q;
  logic s3_q;

  // ==========================================================================
  // chain
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a change counts only once the two late stages agree
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      level_q <= RST_VAL;
    end else if (s2_q == s3_q) begin
      level_q <= s3_q;
    end
  end

endmodule

// File: tb/host_partner.sv
// Purpose: far side model: host serial line, i2c pull-ups, eeprom strobe pull-up
// Assumes: open-drain lines have external pull-ups
// Notes:   the wake edge is made without any clock, like a real host
module host_partner (
  wake_req,
  scl_out,
  scl_oe,
  ee_out,
  ee_oe,
  host_line,
  scl_line,
  ee_line
);
  timeunit 1ns;
  timeprecision 1ps;
  input  wire logic wake_req;
  input  wire logic scl_out;
  input  wire logic scl_oe;
  input  wire logic ee_out;
  input  wire logic ee_oe;
  output logic      host_line;
  output logic      scl_line;
  output logic      ee_line;

  // ==========================================================================
  // host serial line, idles high
  initial begin
    host_line = 1'h1;
    forever begin
      @(posedge wake_req);
      host_line = 1'h0;
      #200 host_line = 1'h1;
    end
  end

  // ==========================================================================
  // pulled-up open-drain wires
  assign scl_line = (scl_oe && !scl_out) ? 1'h0 : 1'h1;
  assign ee_line  = (ee_oe && !ee_out) ? 1'h0 : 1'h1;
endmodule

// File: tb/sleep_wake_pin_control_tb.sv
// Purpose: self-checking bench for the sleep/wake pin control block
// Assumes: settle count shortened to 2; clock 25 MHz stands in for the reference
// Notes:   clock is halted once to prove wake without a running clock
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin num_errors++; \
  $display("[FAIL] %s exp=%0h got=%0h", nm, e, g); end end
`define WAITV(nm, sig, v) begin int n; n = 0; while ((sig) !== (v) && n < 40) begin \
  wait_cyc(1); n++; end `CHK(nm, v, sig) if (n >= 40) end_sim(); end
module sleep_wake_pin_control_tb;
  import pin_ctrl_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0, clk_run = 1'h1, rst_n = 1'h0, csel = 1'h0, sleep_req = 1'h0;
  logic hia = 1'h0, htx = 1'h0, eew = 1'h0, i2c_run = 1'h0, wake_req = 1'h0;
  logic [1:0] aux_d = 2'h0;
  aux_cfg_t cfg1 = '0, cfg2 = '0;
  logic host_line, scl_line, ee_line, osc, lse, hso, hso_oe, ee_o, ee_oe, cab;
  logic scl_o, scl_oe, a1, a1_oe, a2, a2_oe, slp;
  clkin_mode_t mode;
  int num_errors = 0, check_count = 0;

  always #20 clk = clk_run ? ~clk : clk;

  sleep_wake_pin_control #(.SETTLE_CYCLES(2)) sleep_wake_pin_control_i (
    .clk(clk), .rst_n(rst_n), .host_serial_in(host_line), .clock_input_select(csel),
    .sleep_req(sleep_req), .host_if_active(hia), .host_tx_data(htx), .eeprom_write_active(eew),
    .i2c_run(i2c_run), .scl_in(scl_line), .aux_serial_data(aux_d), .aux_cfg_one(cfg1),
    .aux_cfg_two(cfg2), .oscillator_enable_out(osc), .level_shift_enable(lse),
    .host_serial_out(hso), .host_serial_out_oe(hso_oe), .eeprom_write_strobe(ee_o),
    .eeprom_write_strobe_oe(ee_oe), .cable_present_out(cab), .clkin_mode(mode), .scl_out(scl_o),
    .scl_oe(scl_oe), .aux_serial_out_one(a1), .aux_serial_out_one_oe(a1_oe),
    .aux_serial_out_two(a2), .aux_serial_out_two_oe(a2_oe), .sleeping(slp));

  host_partner host_partner_i (
    .wake_req(wake_req), .scl_out(scl_o), .scl_oe(scl_oe), .ee_out(ee_o), .ee_oe(ee_oe),
    .host_line(host_line), .scl_line(scl_line), .ee_line(ee_line));

  // ==========================================================================
  // reference model and helpers
  function automatic logic [1:0] aux_exp(aux_cfg_t c, logic d);
    logic v;
    v = c.gpio_sel ? c.gpio_val : d;
    return c.open_drain ? {1'h0, ~v} : {v, 1'h1};
  endfunction

  task automatic wait_cyc(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic done(string nm);
    $display("test %s finished, errors so far %0d", nm, num_errors);
  endtask

  task automatic end_sim();
    $display("checks %0d, mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic do_reset();
    @(posedge clk) rst_n <= 1'h0;
    wait_cyc(3);
    `CHK("osc_in_reset", 1'h1, osc)
    `CHK("cable_in_reset", 1'h0, cab)
    `CHK("slp_in_reset", 1'h0, slp)
    @(posedge clk) rst_n <= 1'h1;
    wait_cyc(1);
  endtask

  initial begin
    #(40 * 50000);
    num_errors++;
    end_sim();
  end

  // ==========================================================================
  // main sequence
  initial begin
    int t;
    logic [1:0] e;
    void'($urandom(87215));
    do_reset();
    `CHK("osc_run", 1'h1, osc)
    `WAITV("cable_present", cab, 1'h1)
    done("reset");
    for (int i = 0; i < 2; i++) begin
      @(posedge clk) csel <= i[0];
      wait_cyc(8);
      `CHK("clkin_mode", i[0] ? CLKIN_DIFF : CLKIN_XTAL_SE, mode)
    end
    done("clock_mode");
    for (int i = 0; i < 6; i++) begin
      @(posedge clk) begin hia <= (i < 4); htx <= i[0]; end
      wait_cyc(3);
      `CHK("lse", (i < 4) ? 1'h1 : 1'h0, lse)
      `CHK("tx_oe", (i < 4) ? 1'h1 : 1'h0, hso_oe)
      if (i < 4) `CHK("tx_data", i[0], hso)
    end
    done("host_serial");
    for (int i = 0; i < 2; i++) begin
      @(posedge clk) eew <= ~i[0];
      wait_cyc(2);
      `CHK("ee_line", i[0], ee_line)
    end
    done("eeprom_strobe");
    for (int i = 0; i < 24; i++) begin
      @(posedge clk) begin
        cfg1 <= aux_cfg_t'(3'($urandom));
        cfg2 <= aux_cfg_t'(3'($urandom));
        aux_d <= 2'($urandom);
      end
      wait_cyc(3);
      e = aux_exp(cfg1, aux_d[0]);
      `CHK("aux_one", e, {a1, a1_oe})
      e = aux_exp(cfg2, aux_d[1]);
      `CHK("aux_two", e, {a2, a2_oe})
    end
    done("aux");
    @(posedge clk) i2c_run <= 1'h1;
    `WAITV("scl_low", scl_line, 1'h0)
    `WAITV("scl_high", scl_line, 1'h1)
    t = 0;
    while (scl_line !== 1'h0 && t < 200) begin
      wait_cyc(1);
      t++;
    end
    while (scl_line !== 1'h1 && t < 200) begin
      wait_cyc(1);
      t++;
    end
    `CHK("scl_period", 4 * I2C_QTR_CYC, t)
    @(posedge clk) i2c_run <= 1'h0;
    done("i2c_clock");
    @(posedge clk) sleep_req <= 1'h1;
    @(posedge clk) sleep_req <= 1'h0;
    `WAITV("osc_sleep", osc, 1'h0)
    for (int i = 0; i < 30; i++) begin
      wait_cyc(1);
      `CHK("osc_held_low", 1'h0, osc)
    end
    clk_run = 1'h0;
    #100 wake_req = 1'h1;
    #400 clk_run = 1'h1;
    `WAITV("osc_wake", osc, 1'h1)
    wait_cyc(2);
    `CHK("slp_cleared", 1'h0, slp)
    done("sleep_wake");
    // the wake state lasts until the cleared latch has passed the synchroniser
    wait_cyc(8);
    @(posedge clk) sleep_req <= 1'h1;
    @(posedge clk) sleep_req <= 1'h0;
    `WAITV("osc_sleep2", osc, 1'h0)
    do_reset();
    `CHK("osc_after_reset", 1'h1, osc)
    `WAITV("cable_again", cab, 1'h1)
    done("mid_reset");
    end_sim();
  end
endmodule
